// ===== mtc_pkg.sv
// Purpose: shared constants and carrier types for the translation control block
// Assumes: one request at a time, 40 MHz clock
// Notes: window register layout and control register bits are fixed here
package mtc_pkg;
  localparam int ADDR_W = 32;
  localparam int WAYS = 4;
  localparam int SETS = 16;
  localparam int IDX_W = 4;
  localparam int TAG_W = 20;
  localparam int TAG_LSB = 12;
  localparam int IDX_LSB_4K = 12;
  localparam int IDX_LSB_8K = 13;
  localparam int HI_LSB = 24;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'hf;
  localparam logic [TAG_W-1:0] TAG_MASK_4K = 20'hfffff;
  localparam logic [TAG_W-1:0] TAG_MASK_8K = 20'hffffe;
  localparam logic [ADDR_W-1:0] PAGE_MASK_4K = 32'hfffff000;
  localparam logic [ADDR_W-1:0] PAGE_MASK_8K = 32'hffffe000;
  // window register fields
  localparam int WIN_BASE_LSB = 24;
  localparam int WIN_MASK_LSB = 16;
  localparam int WIN_EN = 15;
  localparam int WIN_S_LSB = 13;
  localparam int WIN_U_LSB = 8;
  localparam int WIN_CM_LSB = 5;
  localparam int WIN_WP = 2;
  localparam logic [1:0] WIN_S_USER = 2'h0;
  localparam logic [1:0] WIN_S_SUPER = 2'h1;
  // translation control register fields
  localparam int CTL_EN = 15;
  localparam int CTL_PAGE = 14;
  localparam logic [2:0] SEL_CTL = 3'h0;
  localparam logic [2:0] SEL_DW0 = 3'h1;
  localparam logic [2:0] SEL_DW1 = 3'h2;
  localparam logic [2:0] SEL_IW0 = 3'h3;
  localparam logic [2:0] SEL_IW1 = 3'h4;
  localparam logic [31:0] WIN_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    OP_ACCESS = 2'b00,
    OP_FLUSH_ALL = 2'b01,
    OP_FLUSH_ENTRY = 2'b10,
    OP_PROBE = 2'b11
  } mtc_op_t;

  typedef struct packed {
    logic valid;
    logic sup;
    logic glob;
    logic resident;
    logic wprot;
    logic modified;
    logic [1:0] cm;
    logic [1:0] upa;
    logic [TAG_W-1:0] ltag;
    logic [TAG_W-1:0] ppn;
  } mtc_entry_t;

  typedef mtc_entry_t [WAYS-1:0] mtc_set_t;

  typedef struct packed {
    logic valid;
    mtc_op_t op;
    logic nonglobal;
    logic unit;
    logic sup;
    logic write;
    logic defer;
    logic [ADDR_W-1:0] addr;
  } mtc_req_t;

  typedef struct packed {
    logic done;
    logic transparent;
    logic bus_err;
    logic acc_err;
    logic deferred;
    logic wp;
    logic [1:0] cm;
    logic [1:0] upa;
    logic [ADDR_W-1:0] paddr;
    logic [ADDR_W-1:0] fault_addr;
  } mtc_resp_t;

  typedef struct packed {
    logic valid;
    logic unit;
    logic sup;
    logic set_mod;
    logic [ADDR_W-1:0] addr;
  } mtc_walk_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic resident;
    logic wprot;
    logic modified;
    logic glob;
    logic [1:0] cm;
    logic [1:0] upa;
    logic [TAG_W-1:0] ppn;
  } mtc_walk_rsp_t;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [31:0] data;
  } mtc_cfg_wr_t;

  typedef struct packed {
    logic resident;
    logic wprot;
    logic modified;
    logic glob;
    logic transparent;
    logic bus_err;
    logic [TAG_W-1:0] ppn;
  } mtc_status_t;
endpackage

// ===== mtc_window_match.sv
// Purpose: one transparent window compare
// Assumes: window register layout from mtc_pkg
// Notes: purely combinational
`timescale 1ns/10ps
module mtc_window_match (
  input wire logic [31:0] win,
  input wire logic sup,
  input wire logic [7:0] addr_hi,
  output logic hit
);
  logic [7:0] base;
  logic [7:0] mask;
  logic [1:0] sfield;
  logic priv_ok;

  always_comb begin
    base = win[mtc_pkg::WIN_BASE_LSB +: 8];
    mask = win[mtc_pkg::WIN_MASK_LSB +: 8];
    sfield = win[mtc_pkg::WIN_S_LSB +: 2];
    if (sfield == mtc_pkg::WIN_S_USER) begin
      priv_ok = !sup;
    end else if (sfield == mtc_pkg::WIN_S_SUPER) begin
      priv_ok = sup;
    end else begin
      priv_ok = 1'b1;
    end
    // masked base bits drop out of the compare
    hit = win[mtc_pkg::WIN_EN] && priv_ok && (((base ^ addr_hi) & ~mask) == 8'h00);
  end
endmodule

// ===== mtc_set_mem.sv
// Purpose: storage for one translation cache, one set per word
// Assumes: single read port and single write port
// Notes: contents are not reset; read data is registered
`timescale 1ns/10ps
module mtc_set_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 200,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== mtc_translation_control.sv
// Purpose: address translation control for the data and instruction units
// Assumes: one access or management request at a time; table walks done outside
// Notes: unit 0 is data, unit 1 is instruction; flushes act on both caches
//
// What this block does
// - four windows, two per unit, 16 MB minimum
// - compare privilege and top eight address bits
// - window privilege field: user, supervisor or both
// - mask bits drop base bits from compare
// - disabled window never matches
// - write-protected window aborts writes
// - window hit passes address; first window wins
// - windows before cache; walk on miss, first write or probe
// - walk suspends, fills valid entry, retries access
// - hit on failed-walk entry gives bus error
// - write hit on protected entry gives access error
// - first write walks to set modified, retries
// - cached read needs resident; cached write needs resident and modified
// - deferred next-page error reported after prefetch attempt
// - deferred fault address is missing page start
// - reset clears control and window enables
// - disabled translation supplies all-zero attributes
// - reset keeps cache entries and page size
// - disable input stops cache and walks at boundary
// - flush all, by entry, or nonglobal only
// - probe invalidates, walks, fills, updates status
// - register access never touches cache contents
// - four ways, 64 entries, invalid slot first
// - two-bit access counter picks replacement way
`timescale 1ns/10ps
module mtc_translation_control (
  input wire logic clock,
  input wire logic rst,
  input wire mtc_pkg::mtc_req_t req,
  output logic ready_q,
  output mtc_pkg::mtc_resp_t resp_q,
  output logic suspend_q,
  input wire logic translation_disable_input,
  output mtc_pkg::mtc_walk_req_t walk_q,
  input wire mtc_pkg::mtc_walk_rsp_t walk_rsp,
  input wire mtc_pkg::mtc_cfg_wr_t cfg,
  output logic [31:0] rd_data_q,
  output mtc_pkg::mtc_status_t status_q
);
  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_CHECK = 3'b010,
    ST_WALK = 3'b011,
    ST_FILL = 3'b100
  } mtc_fsm_t;

  typedef struct packed {
    mtc_fsm_t fsm;
    logic dis;
    logic ctl_en;
    logic page8k;
    logic [3:0][31:0] win;
    logic [1:0][1:0] cnt;
    mtc_pkg::mtc_req_t cur;
    logic [mtc_pkg::IDX_W-1:0] idx;
    logic [1:0] fill_way;
    logic set_mod;
    logic probe_tt;
    mtc_pkg::mtc_set_t set;
    mtc_pkg::mtc_walk_rsp_t wres;
    logic ready;
    logic suspend;
    mtc_pkg::mtc_resp_t resp;
    mtc_pkg::mtc_walk_req_t walk;
    logic [31:0] rd_data;
    mtc_pkg::mtc_status_t status;
  } mtc_state_t;

  mtc_state_t s_q;
  mtc_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // windows and cache memories
  logic [3:0] win_hit;
  logic [1:0] req_unit_hit;
  mtc_pkg::mtc_set_t rd_set [2];
  logic [1:0] mem_we;
  mtc_pkg::mtc_set_t mem_wdata [2];

  for (genvar w = 0; w < 4; w++) begin : g_win
    mtc_window_match u_win (
      .win(s_q.win[w]),
      .sup(req.sup),
      .addr_hi(req.addr[mtc_pkg::HI_LSB +: 8]),
      .hit(win_hit[w])
    );
  end

  // both windows of the requesting unit are checked on every access
  assign req_unit_hit = req.unit ? win_hit[3:2] : win_hit[1:0];

  for (genvar u = 0; u < 2; u++) begin : g_mem
    mtc_set_mem #(
      .DEPTH(mtc_pkg::SETS),
      .WIDTH($bits(mtc_pkg::mtc_set_t)),
      .AW(mtc_pkg::IDX_W)
    ) u_mem (
      .clock(clock),
      .rd_addr(s_q.idx),
      .rd_data(rd_set[u]),
      .wr_en(mem_we[u]),
      .wr_addr(s_q.idx),
      .wr_data(mem_wdata[u])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic tag_match(input mtc_pkg::mtc_entry_t e, input logic sup,
                                     input logic [31:0] a, input logic p8k);
    logic [mtc_pkg::TAG_W-1:0] tmask;
    tmask = p8k ? mtc_pkg::TAG_MASK_8K : mtc_pkg::TAG_MASK_4K;
    tag_match = e.valid && (e.sup == sup) &&
                (((e.ltag ^ a[mtc_pkg::TAG_LSB +: mtc_pkg::TAG_W]) & tmask) == '0);
  endfunction

  function automatic logic [1:0] pick_way(input mtc_pkg::mtc_set_t st, input logic [1:0] ctr);
    logic found;
    pick_way = ctr;
    found = 1'b0;
    for (int w = 0; w < mtc_pkg::WAYS; w++) begin
      if (!found && !st[w].valid) begin
        pick_way = 2'(w);
        found = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  logic [mtc_pkg::IDX_W-1:0] req_idx;
  logic hit_any;
  logic [1:0] hit_way;
  logic [31:0] win_w;
  mtc_pkg::mtc_set_t cset;
  mtc_pkg::mtc_entry_t he;
  mtc_pkg::mtc_entry_t ne;
  logic clr;

  always_comb begin
    s_d = s_q;
    s_d.resp.done = 1'b0;
    mem_we = 2'b00;
    mem_wdata[0] = rd_set[0];
    mem_wdata[1] = rd_set[1];
    hit_any = 1'b0;
    hit_way = 2'b00;
    he = '0;
    ne = '0;
    clr = 1'b0;
    cset = s_q.cur.unit ? rd_set[1] : rd_set[0];
    win_w = s_q.win[req.unit ? 3 : 1];
    if (s_q.page8k) begin
      req_idx = req.addr[mtc_pkg::IDX_LSB_8K +: mtc_pkg::IDX_W];
    end else begin
      req_idx = req.addr[mtc_pkg::IDX_LSB_4K +: mtc_pkg::IDX_W];
    end
    if (req_unit_hit[0]) begin
      win_w = s_q.win[req.unit ? 2 : 0];
    end

    // register writes only change the registers, never the caches
    if (cfg.wr) begin
      unique case (cfg.sel)
        mtc_pkg::SEL_CTL: begin
          s_d.ctl_en = cfg.data[mtc_pkg::CTL_EN];
          s_d.page8k = cfg.data[mtc_pkg::CTL_PAGE];
        end
        mtc_pkg::SEL_DW0: s_d.win[0] = cfg.data;
        mtc_pkg::SEL_DW1: s_d.win[1] = cfg.data;
        mtc_pkg::SEL_IW0: s_d.win[2] = cfg.data;
        mtc_pkg::SEL_IW1: s_d.win[3] = cfg.data;
        default: begin
        end
      endcase
    end
    unique case (cfg.sel)
      mtc_pkg::SEL_CTL: begin
        s_d.rd_data = '0;
        s_d.rd_data[mtc_pkg::CTL_EN] = s_q.ctl_en;
        s_d.rd_data[mtc_pkg::CTL_PAGE] = s_q.page8k;
      end
      mtc_pkg::SEL_DW0: s_d.rd_data = s_q.win[0];
      mtc_pkg::SEL_DW1: s_d.rd_data = s_q.win[1];
      mtc_pkg::SEL_IW0: s_d.rd_data = s_q.win[2];
      mtc_pkg::SEL_IW1: s_d.rd_data = s_q.win[3];
      default: s_d.rd_data = '0;
    endcase

    unique case (s_q.fsm)
      ST_IDLE: begin
        // the disable input is taken only between accesses
        s_d.dis = translation_disable_input;
        if (req.valid) begin
          s_d.cur = req;
          s_d.idx = (req.op == mtc_pkg::OP_FLUSH_ALL) ? '0 : req_idx;
          s_d.set_mod = 1'b0;
          s_d.probe_tt = |req_unit_hit;
          if (req.op != mtc_pkg::OP_ACCESS) begin
            s_d.fsm = ST_LOOK;
          end else if (|req_unit_hit) begin
            s_d.resp.done = 1'b1;
            s_d.resp.transparent = 1'b1;
            s_d.resp.paddr = req.addr;
            s_d.resp.fault_addr = req.addr;
            s_d.resp.wp = win_w[mtc_pkg::WIN_WP];
            s_d.resp.cm = win_w[mtc_pkg::WIN_CM_LSB +: 2];
            s_d.resp.upa = win_w[mtc_pkg::WIN_U_LSB +: 2];
            s_d.resp.acc_err = req.write && win_w[mtc_pkg::WIN_WP];
            s_d.resp.bus_err = 1'b0;
            s_d.resp.deferred = 1'b0;
          end else if (!s_q.ctl_en || translation_disable_input) begin
            s_d.resp = '0;
            s_d.resp.done = 1'b1;
            s_d.resp.paddr = req.addr;
            s_d.resp.fault_addr = req.addr;
          end else begin
            s_d.fsm = ST_LOOK;
          end
        end
      end
      ST_LOOK: begin
        if (s_q.cur.op == mtc_pkg::OP_ACCESS || s_q.cur.op == mtc_pkg::OP_PROBE) begin
          s_d.cnt[s_q.cur.unit] = s_q.cnt[s_q.cur.unit] + 2'h1;
        end
        s_d.fsm = ST_CHECK;
      end
      ST_CHECK: begin
        for (int w = 0; w < mtc_pkg::WAYS; w++) begin
          if (!hit_any && tag_match(cset[w], s_q.cur.sup, s_q.cur.addr, s_q.page8k)) begin
            hit_any = 1'b1;
            hit_way = 2'(w);
          end
        end
        he = cset[hit_way];
        s_d.set = cset;
        unique case (s_q.cur.op)
          mtc_pkg::OP_FLUSH_ALL, mtc_pkg::OP_FLUSH_ENTRY: begin
            for (int u = 0; u < 2; u++) begin
              for (int w = 0; w < mtc_pkg::WAYS; w++) begin
                clr = (s_q.cur.op == mtc_pkg::OP_FLUSH_ALL) ||
                      tag_match(rd_set[u][w], s_q.cur.sup, s_q.cur.addr, s_q.page8k);
                if (clr && !(s_q.cur.nonglobal && rd_set[u][w].glob)) begin
                  mem_wdata[u][w].valid = 1'b0;
                end
              end
            end
            mem_we = 2'b11;
            if (s_q.cur.op == mtc_pkg::OP_FLUSH_ALL && s_q.idx != mtc_pkg::IDX_LAST) begin
              s_d.idx = s_q.idx + 4'h1;
              s_d.fsm = ST_LOOK;
            end else begin
              s_d.fsm = ST_IDLE;
            end
          end
          mtc_pkg::OP_PROBE: begin
            for (int w = 0; w < mtc_pkg::WAYS; w++) begin
              if (tag_match(cset[w], s_q.cur.sup, s_q.cur.addr, s_q.page8k)) begin
                cset[w].valid = 1'b0;
              end
            end
            mem_wdata[s_q.cur.unit] = cset;
            mem_we[s_q.cur.unit] = 1'b1;
            s_d.set = cset;
            s_d.fill_way = pick_way(cset, s_q.cnt[s_q.cur.unit]);
            s_d.fsm = ST_WALK;
          end
          default: begin
            if (hit_any && !he.resident) begin
              s_d.resp = '0;
              s_d.resp.done = 1'b1;
              s_d.resp.bus_err = 1'b1;
              s_d.resp.deferred = s_q.cur.defer;
              s_d.resp.fault_addr = s_q.cur.addr;
              if (s_q.cur.defer) begin
                s_d.resp.fault_addr = s_q.cur.addr & (s_q.page8k ? mtc_pkg::PAGE_MASK_8K
                                                                : mtc_pkg::PAGE_MASK_4K);
              end
              s_d.fsm = ST_IDLE;
            end else if (hit_any && s_q.cur.write && he.wprot) begin
              s_d.resp = '0;
              s_d.resp.done = 1'b1;
              s_d.resp.acc_err = 1'b1;
              s_d.resp.fault_addr = s_q.cur.addr;
              s_d.fsm = ST_IDLE;
            end else if (hit_any && s_q.cur.write && !he.modified) begin
              s_d.set_mod = 1'b1;
              s_d.fill_way = hit_way;
              s_d.fsm = ST_WALK;
            end else if (hit_any) begin
              s_d.resp = '0;
              s_d.resp.done = 1'b1;
              s_d.resp.wp = he.wprot;
              s_d.resp.cm = he.cm;
              s_d.resp.upa = he.upa;
              s_d.resp.fault_addr = s_q.cur.addr;
              s_d.resp.paddr = {he.ppn[mtc_pkg::TAG_W-1:1],
                                s_q.page8k ? s_q.cur.addr[mtc_pkg::TAG_LSB] : he.ppn[0],
                                s_q.cur.addr[mtc_pkg::TAG_LSB-1:0]};
              s_d.fsm = ST_IDLE;
            end else begin
              s_d.fill_way = pick_way(cset, s_q.cnt[s_q.cur.unit]);
              s_d.fsm = ST_WALK;
            end
          end
        endcase
        if (s_d.fsm == ST_WALK) begin
          s_d.walk.valid = 1'b1;
          s_d.walk.unit = s_q.cur.unit;
          s_d.walk.sup = s_q.cur.sup;
          s_d.walk.set_mod = s_d.set_mod;
          s_d.walk.addr = s_q.cur.addr;
        end
      end
      ST_WALK: begin
        if (walk_rsp.done) begin
          s_d.walk.valid = 1'b0;
          s_d.wres = walk_rsp;
          s_d.fsm = ST_FILL;
        end
      end
      ST_FILL: begin
        ne.valid = 1'b1;
        ne.sup = s_q.cur.sup;
        ne.glob = s_q.wres.glob;
        ne.resident = s_q.wres.resident && !s_q.wres.err;
        ne.wprot = s_q.wres.wprot;
        ne.modified = s_q.wres.modified || s_q.set_mod;
        ne.cm = s_q.wres.cm;
        ne.upa = s_q.wres.upa;
        ne.ltag = s_q.cur.addr[mtc_pkg::TAG_LSB +: mtc_pkg::TAG_W];
        ne.ppn = s_q.wres.ppn;
        mem_wdata[s_q.cur.unit] = s_q.set;
        mem_wdata[s_q.cur.unit][s_q.fill_way] = ne;
        mem_we[s_q.cur.unit] = 1'b1;
        if (s_q.cur.op == mtc_pkg::OP_PROBE) begin
          s_d.status.resident = ne.resident;
          s_d.status.wprot = ne.wprot;
          s_d.status.modified = ne.modified;
          s_d.status.glob = ne.glob;
          s_d.status.transparent = s_q.probe_tt;
          s_d.status.bus_err = s_q.wres.err;
          s_d.status.ppn = ne.ppn;
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.fsm = ST_LOOK;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase

    // reset clears enables but keeps page size and cache contents
    if (rst) begin
      s_d.fsm = ST_IDLE;
      s_d.ctl_en = 1'b0;
      s_d.win = {4{mtc_pkg::WIN_RESET}};
      s_d.dis = 1'b0;
      s_d.cnt = '0;
      s_d.cur = '0;
      s_d.idx = '0;
      s_d.fill_way = 2'h0;
      s_d.set_mod = 1'b0;
      s_d.probe_tt = 1'b0;
      s_d.set = '0;
      s_d.wres = '0;
      s_d.resp = '0;
      s_d.walk = '0;
      s_d.rd_data = '0;
      s_d.status = '0;
      mem_we = 2'b00;
    end
    s_d.ready = (s_d.fsm == ST_IDLE) && !rst;
    s_d.suspend = (s_d.fsm == ST_WALK) || (s_d.fsm == ST_FILL);
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ready_q = s_q.ready;
  assign resp_q = s_q.resp;
  assign suspend_q = s_q.suspend;
  assign walk_q = s_q.walk;
  assign rd_data_q = s_q.rd_data;
  assign status_q = s_q.status;
endmodule

// ===== mtc_translation_control_asserts.sv
// Purpose: port checks for the translation control block
// Assumes: one request at a time
// Notes: bound to mtc_translation_control
`timescale 1ns/10ps
module mtc_translation_control_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire mtc_pkg::mtc_req_t req,
  input wire logic ready_q,
  input wire mtc_pkg::mtc_resp_t resp_q,
  input wire logic suspend_q,
  input wire logic translation_disable_input,
  input wire mtc_pkg::mtc_walk_req_t walk_q,
  input wire mtc_pkg::mtc_walk_rsp_t walk_rsp,
  input wire mtc_pkg::mtc_cfg_wr_t cfg,
  input wire logic [31:0] rd_data_q,
  input wire mtc_pkg::mtc_status_t status_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic en_q, wen_q, wr_q;
  wire tk = req.valid && ready_q && req.op == mtc_pkg::OP_ACCESS;
  // tracks control enable, any window ever enabled, and the write flag of the last access
  always_ff @(posedge clock) begin
    if (rst) begin
      en_q <= 1'b0;
      wen_q <= 1'b0;
    end else if (cfg.wr && cfg.sel == mtc_pkg::SEL_CTL) begin
      en_q <= cfg.data[mtc_pkg::CTL_EN];
    end else if (cfg.wr && cfg.data[mtc_pkg::WIN_EN]) begin
      wen_q <= 1'b1;
    end
    if (tk) begin
      wr_q <= req.write;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !ready_q && !walk_q.valid)
    else $error("outputs not idle after reset");
  a_off_passthru: assert property (tk && !en_q && !wen_q |=> resp_q.done
    && resp_q.paddr == $past(req.addr) && {resp_q.wp, resp_q.cm, resp_q.upa} == 5'h0)
    else $error("untranslated access wrong");
  a_disable_nowalk: assert property (tk && translation_disable_input |=> !walk_q.valid [*4])
    else $error("walk while disabled");
  a_walk_suspends: assert property (walk_q.valid |-> suspend_q)
    else $error("walk without suspend");
  a_walk_holds: assert property (walk_q.valid && !walk_rsp.done |=>
    walk_q.valid && $stable(walk_q.addr))
    else $error("walk request dropped");
  a_walk_retry: assert property (walk_rsp.done && walk_q.valid |-> ##[1:6] ready_q)
    else $error("no completion after walk");
  a_berr_cause: assert property (resp_q.done && resp_q.bus_err |->
    !resp_q.transparent && !resp_q.acc_err)
    else $error("bus error with other outcome");
  a_accerr_write: assert property (resp_q.done && resp_q.acc_err |-> wr_q)
    else $error("access error on read");
  a_setmod_write: assert property (walk_q.valid && walk_q.set_mod |-> wr_q)
    else $error("modify walk on read");
endmodule
bind mtc_translation_control mtc_translation_control_asserts u_sva (.clock(clock), .rst(rst),
  .req(req), .ready_q(ready_q), .resp_q(resp_q), .suspend_q(suspend_q),
  .translation_disable_input(translation_disable_input), .walk_q(walk_q),
  .walk_rsp(walk_rsp), .cfg(cfg), .rd_data_q(rd_data_q), .status_q(status_q));

// ===== mtc_walk_model.sv
// Purpose: table walk responder on the far side
// Assumes: one walk outstanding
// Notes: fields toggle outside the done pulse
`timescale 1ns/10ps
module mtc_walk_model (
  input wire logic clock,
  input wire logic rst,
  input wire mtc_pkg::mtc_walk_req_t walk_q,
  input wire logic err,
  input wire logic wprot,
  input wire logic glb,
  input wire logic [3:0] lat,
  output mtc_pkg::mtc_walk_rsp_t walk_rsp
);
  logic [3:0] cnt;
  initial walk_rsp = '0;
  always @(posedge clock) begin
    if (rst || !walk_q.valid || walk_rsp.done) begin
      cnt <= 4'h0;
      walk_rsp <= {1'b0, ~walk_rsp[28:0]};
    end else if (cnt == lat) begin
      walk_rsp <= '{1'b1, err, !err, wprot, walk_q.set_mod, glb, 2'h1, 2'h3,
        walk_q.addr[31:12] ^ 20'h80000};
    end else begin
      cnt <= cnt + 4'h1;
      walk_rsp <= {1'b0, ~walk_rsp[28:0]};
    end
  end
endmodule

// ===== mtc_translation_control_bench.sv
// Purpose: scenario bench for the translation control block
// Assumes: walk model maps page p to p xor 80000
// Notes: walks counted on rising walk request
`timescale 1ns/10ps
module mtc_translation_control_bench;
  localparam mtc_pkg::mtc_op_t AC = mtc_pkg::OP_ACCESS;
  localparam mtc_pkg::mtc_op_t FL = mtc_pkg::OP_FLUSH_ALL;
  localparam mtc_pkg::mtc_op_t FE = mtc_pkg::OP_FLUSH_ENTRY;
  localparam mtc_pkg::mtc_op_t PR = mtc_pkg::OP_PROBE;
  localparam logic [31:0] WM = 32'hffffe364;
  logic clock, rst, dis, err, wp, glb, rdy, sus, wv;
  logic [3:0] lat;
  logic [31:0] rd;
  mtc_pkg::mtc_req_t r;
  mtc_pkg::mtc_resp_t rs;
  mtc_pkg::mtc_walk_req_t wq;
  mtc_pkg::mtc_walk_rsp_t wr;
  mtc_pkg::mtc_cfg_wr_t cfg;
  mtc_pkg::mtc_status_t st;
  int n_mismatch, comparisons, n_walk;
  always #12.5 clock = ~clock;
  mtc_translation_control DUT (.clock(clock), .rst(rst), .req(r), .ready_q(rdy), .resp_q(rs),
    .suspend_q(sus), .translation_disable_input(dis), .walk_q(wq), .walk_rsp(wr), .cfg(cfg),
    .rd_data_q(rd), .status_q(st));
  mtc_walk_model far (.clock(clock), .rst(rst), .walk_q(wq), .err(err), .wprot(wp),
    .glb(glb), .lat(lat), .walk_rsp(wr));
  always @(posedge clock) begin
    wv <= wq.valid;
    if (wq.valid && !wv) n_walk <= n_walk + 1;
  end
  task automatic cmp(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic go(input mtc_pkg::mtc_op_t op, input logic ng, u, s, w, d,
    input logic [31:0] a);
    int k;
    r <= '{1'b1, op, ng, u, s, w, d, a};
    @(posedge clock);
    while (!rdy) @(posedge clock);
    r.valid <= 1'b0;
    for (k = 0; k < 99; k++) begin
      @(posedge clock);
      if (op == AC ? rs.done : rdy) break;
    end
    if (k == 99) cmp("busy", 1, 0);
  endtask
  task automatic wc(input logic [2:0] sel, input logic [31:0] d, m);
    cfg <= '{1'b1, sel, d};
    @(posedge clock);
    cfg.wr <= 1'b0;
    repeat (2) @(posedge clock);
    cmp("readback", rd, d & m);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_off;
    cfg.sel <= 3'h1;
    repeat (2) @(posedge clock);
    cmp("win_rst", rd, 0);
    go(AC, 0, 0, 0, 1, 0, 32'h12345678);
    cmp("off_pa", rs.paddr, 32'h12345678);
    cmp("off_attr", {rs.wp, rs.cm, rs.upa}, 0);
    wc(3'h0, 32'h00008000, 32'h0000c000);
    go(FL, 0, 0, 0, 0, 0, 0);
  endtask
  task automatic t_win;
    wc(3'h1, 32'h4000c224, WM);
    wc(3'h2, 32'h400fc060, WM);
    go(AC, 0, 0, 0, 0, 0, 32'h40001234);
    cmp("tt", {rs.transparent, rs.cm, rs.upa}, 5'h16);
    cmp("tt_pa", rs.paddr, 32'h40001234);
    go(AC, 0, 0, 0, 1, 0, 32'h40001234);
    cmp("tt_wp", rs.acc_err, 1);
    go(AC, 0, 0, 0, 1, 0, 32'h4f000010);
    cmp("mask", {rs.transparent, rs.acc_err, rs.cm}, 4'hb);
    go(AC, 0, 1, 0, 0, 0, 32'h40001234);
    cmp("unit", rs.paddr, 32'hc0001234);
    wc(3'h2, 32'h400f8060, WM);
    go(AC, 0, 0, 1, 0, 0, 32'h4f000010);
    cmp("priv", rs.transparent, 0);
    wc(3'h1, 32'h40004224, WM);
    go(AC, 0, 0, 0, 0, 0, 32'h40001234);
    cmp("win_off", rs.cm, 3);
  endtask
  task automatic t_walk;
    int n;
    n = n_walk;
    go(AC, 0, 0, 0, 0, 0, 32'h00123456);
    cmp("miss_pa", rs.paddr, 32'h80123456);
    cmp("miss", n_walk, n + 1);
    go(AC, 0, 0, 0, 0, 0, 32'h00123456);
    cmp("hit", n_walk, n + 1);
    go(AC, 0, 0, 0, 1, 0, 32'h00123456);
    cmp("mod_walk", n_walk, n + 2);
    wc(3'h4, 32'h0, WM);
    go(AC, 0, 0, 0, 1, 0, 32'h00123456);
    cmp("mod_hit", n_walk, n + 2);
    cmp("mod_pa", rs.paddr, 32'h80123456);
  endtask
  task automatic t_fault;
    err <= 1'b1;
    lat <= 4'h9;
    go(AC, 0, 1, 0, 0, 1, 32'h00200ffe);
    cmp("berr", {rs.bus_err, rs.deferred}, 2'h3);
    cmp("fault_addr", rs.fault_addr, 32'h00200000);
    err <= 1'b0;
    lat <= 4'h0;
    wp <= 1'b1;
    go(AC, 0, 0, 0, 0, 0, 32'h00300010);
    go(AC, 0, 0, 0, 1, 0, 32'h00300010);
    cmp("wprot", rs.acc_err, 1);
    wp <= 1'b0;
  endtask
  task automatic t_dis;
    int n;
    dis <= 1'b1;
    n = n_walk;
    go(AC, 0, 0, 0, 0, 0, 32'h00500000);
    cmp("dis_pa", rs.paddr, 32'h00500000);
    cmp("dis_walk", n_walk, n);
    go(AC, 0, 0, 0, 0, 0, 32'h4f000010);
    cmp("dis_tt", rs.transparent, 1);
    dis <= 1'b0;
  endtask
  task automatic t_flush;
    int n;
    go(FE, 0, 0, 0, 0, 0, 32'h00123456);
    n = n_walk;
    go(AC, 0, 0, 0, 0, 0, 32'h00123456);
    cmp("fl_entry", n_walk, n + 1);
    glb <= 1'b1;
    go(AC, 0, 0, 0, 0, 0, 32'h00600000);
    glb <= 1'b0;
    go(FL, 1, 0, 0, 0, 0, 0);
    go(AC, 0, 0, 0, 0, 0, 32'h00600000);
    go(AC, 0, 0, 0, 0, 0, 32'h00123456);
    cmp("fl_ng", n_walk, n + 3);
  endtask
  task automatic t_probe;
    int n;
    go(PR, 0, 0, 0, 0, 0, 32'h00700000);
    cmp("pr_st", {st.resident, st.ppn}, 21'h180700);
    n = n_walk;
    go(AC, 0, 0, 0, 0, 0, 32'h00700000);
    cmp("pr_fill", n_walk, n);
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {dis, err, wp, glb, wv} = 5'h0;
    lat = 4'h3;
    r = '0;
    cfg = '0;
    {n_mismatch, comparisons, n_walk} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_off;
    t_win;
    t_walk;
    t_fault;
    t_dis;
    t_flush;
    t_probe;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test;
  end
endmodule
